// [mcs_motor_shaping.sv]
// Motor command shaping with emergency stop, inversion and overheat handling
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "mcs_defs.svh"
module mcs_motor_shaping
#(
    parameter int unsigned INV_CYCLES  = `MCS_INV_CYCLES,
    parameter longint unsigned DER1_CYCLES = `MCS_DER1_CYCLES,
    parameter longint unsigned DER2_CYCLES = `MCS_DER2_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        programButton,
    input  wire logic        setButton,
    input  wire logic        external_stop_or_flip_input,
    // Power stage commands, sign-magnitude
    output logic [7:0]       motor1Drive,
    output logic [7:0]       motor2Drive,
    output logic             motorsOff
);
    mcs_pkg::mcs_state_s s;
    mcs_pkg::mcs_state_s next_s;

    // Curve on a 7-bit magnitude
    function automatic logic [6:0] shape(input logic [2:0] c, input logic [6:0] m);
        logic [13:0] sq;
        logic [6:0]  e2;
        logic [13:0] em;
        logic [6:0]  e1;
        logic [6:0]  inv;
        logic [13:0] isq;
        logic [6:0]  l4;
        // Divide by full scale so every curve ends at full
        sq  = 14'(m) * 14'(m);
        e2  = 7'(sq / 14'h007f);
        em  = 14'(e2) * 14'(m);
        e1  = 7'(em / 14'h007f);
        inv = 7'h7f - m;
        isq = 14'(inv) * 14'(inv);
        l4  = 7'h7f - 7'(isq / 14'h007f);
        unique case (c)
            3'h0: shape = m;
            3'h1: shape = e1;
            3'h2: shape = e2;
            3'h3: shape = 7'(({1'b0, m} + {1'b0, l4}) >> 1);
            3'h4: shape = l4;
            default: shape = m;
        endcase
    endfunction : shape

    // Tuning factor of 1/1000 magnitude, 15 per step
    function automatic logic [9:0] tune_pct(input logic [3:0] t);
        logic [3:0] d;
        d = (t >= `MCS_TUNE_NEUTRAL) ? (t - `MCS_TUNE_NEUTRAL) : (`MCS_TUNE_NEUTRAL - t);
        if (t == 4'hd)
            d = 4'h6;
        tune_pct = 10'(1000 - 15 * d);
    endfunction : tune_pct

    // Full channel path, magnitude scaled after the curve
    function automatic logic [7:0] chan(input logic [7:0] cmd, input logic [2:0] c, input logic [3:0] t,
                                        input logic cl, input logic fl, input logic [1:0] lim);
        logic        neg;
        logic [6:0]  m;
        logic [16:0] p;
        neg = cmd[7] ^ fl;
        m = shape(c, cmd[6:0]);
        // Slow only the side matching the sign of the offset: reverse above neutral, forward below
        if (!cl && t != `MCS_TUNE_NEUTRAL && (neg == (t > `MCS_TUNE_NEUTRAL)))
        begin
            p = 17'(m) * 17'(tune_pct(t));
            m = 7'(p / 17'd1000);
        end
        else
        begin
            p = 17'h0;
        end
        if (lim == 2'h1)
            m = m >> 1;
        else if (lim == 2'h2)
            m = m >> 2;
        chan = (m == 7'h0) ? 8'h00 : {neg, m};
    endfunction : chan

    logic        hot;
    logic        swOn;
    logic [1:0]  lim;
    logic        writeGo;
    logic [31:0] rd;

    always_comb
    begin
        next_s = s;
        writeGo = 1'b0;
        rd = 32'h0;
        lim = 2'h0;
        // Pin synchroniser, first stage read only by the second
        next_s.pin = {s.pin[1:0], external_stop_or_flip_input};
        swOn = s.swState;
        // Bus write
        if (s_axi_awvalid && !s.bus.awv && !s.bus.bvalid)
        begin
            next_s.bus.awv = 1'b1;
            next_s.bus.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.bus.wv && !s.bus.bvalid)
        begin
            next_s.bus.wv = 1'b1;
            next_s.bus.wd = s_axi_wdata;
        end
        if (s.bus.awv && s.bus.wv)
        begin
            writeGo = 1'b1;
            next_s.bus.awv = 1'b0;
            next_s.bus.wv = 1'b0;
            next_s.bus.bvalid = 1'b1;
            next_s.bus.bresp = 2'h0;
            unique case (s.bus.awa[11:2])
                10'(`MCS_OFF_CTRL >> 2): next_s.ctrl = s.bus.wd[24:0];
                10'(`MCS_OFF_CMD >> 2):
                begin
                    next_s.cmd1 = s.bus.wd[7:0];
                    next_s.cmd2 = s.bus.wd[15:8];
                end
                10'(`MCS_OFF_TEMP >> 2):
                begin
                    next_s.temp1 = s.bus.wd[7:0];
                    next_s.temp2 = s.bus.wd[15:8];
                end
                default: next_s.bus.bresp = 2'h2;
            endcase
        end
        if (s.bus.bvalid && s_axi_bready)
            next_s.bus.bvalid = 1'b0;
        // Bus read
        if (s_axi_arvalid && !s.bus.rvalid)
        begin
            unique case (s_axi_araddr[11:2])
                10'(`MCS_OFF_CTRL >> 2): rd = {7'h0, s.ctrl};
                10'(`MCS_OFF_CMD >> 2): rd = {16'h0, s.cmd2, s.cmd1};
                10'(`MCS_OFF_TEMP >> 2): rd = {16'h0, s.temp2, s.temp1};
                10'(`MCS_OFF_STATUS >> 2): rd = {24'h0, 1'b0, s.hs, s.flip, s.swState, s.estop, hot};
                10'(`MCS_OFF_OUT >> 2): rd = {16'h0, s.out2, s.out1};
                default: rd = 32'h0;
            endcase
            next_s.bus.rvalid = 1'b1;
            next_s.bus.rdata = rd;
            next_s.bus.rresp = (s_axi_araddr[11:2] > 10'(`MCS_OFF_OUT >> 2)) ? 2'h2 : 2'h0;
        end
        else if (s.bus.rvalid && s_axi_rready)
            next_s.bus.rvalid = 1'b0;
        // Debounced switch state
        if (s.pin[2] == s.pin[1] && s.pin[1] != s.swState)
        begin
            if (s.invCnt >= 27'(INV_CYCLES - 1))
            begin
                next_s.swState = s.pin[1];
                next_s.invCnt = 27'h0;
            end
            else
                next_s.invCnt = s.invCnt + 27'h1;
        end
        else
            next_s.invCnt = 27'h0;
        next_s.flip = s.swState && s.ctrl.mixed && s.ctrl.sw == mcs_pkg::MCS_SW_FLIP;
        // Emergency stop latch
        if ((programButton && setButton) || (s.swState && s.ctrl.sw == mcs_pkg::MCS_SW_STOP))
            next_s.estop = 1'b1;
        // Overheat handling
        hot = s.ctrl.thr != 8'h0 && (s.temp1 >= s.ctrl.thr || s.temp2 >= s.ctrl.thr);
        unique case (s.hs)
            mcs_pkg::MCS_HS_OK:
            begin
                next_s.hotCnt = 35'h0;
                if (hot && s.ctrl.hot == 2'(mcs_pkg::MCS_HOT_STOP))
                    next_s.hs = mcs_pkg::MCS_HS_STOP;
                else if (hot && s.ctrl.hot != 2'(mcs_pkg::MCS_HOT_NONE))
                    next_s.hs = mcs_pkg::MCS_HS_DERATE;
            end
            mcs_pkg::MCS_HS_DERATE:
            begin
                lim = (s.ctrl.hot == 2'(mcs_pkg::MCS_HOT_D25)) ? 2'h2 : 2'h1;
                next_s.hotCnt = s.hotCnt + 35'h1;
                if (!hot)
                    next_s.hs = mcs_pkg::MCS_HS_OK;
                else if (s.hotCnt >= 35'((lim == 2'h2 ? DER2_CYCLES : DER1_CYCLES) - 1))
                    next_s.hs = mcs_pkg::MCS_HS_STOP;
            end
            mcs_pkg::MCS_HS_STOP:
                if (!hot)
                    next_s.hs = mcs_pkg::MCS_HS_OK;
            default: next_s.hs = mcs_pkg::MCS_HS_OK;
        endcase
        // Outputs
        if (next_s.estop || s.hs == mcs_pkg::MCS_HS_STOP)
        begin
            next_s.out1 = 8'h00;
            next_s.out2 = 8'h00;
        end
        else
        begin
            next_s.out1 = chan(s.cmd1, s.ctrl.curve1, s.ctrl.tune, s.ctrl.cl1, s.flip, lim);
            next_s.out2 = chan(s.cmd2, s.ctrl.curve2, s.ctrl.tune, s.ctrl.cl2, s.flip, lim);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.ctrl <= `MCS_CTRL_RESET;
            s.hs <= mcs_pkg::MCS_HS_OK;
        end
        else
            s <= next_s;
    end

    assign s_axi_awready = s.bus.awv && s.bus.wv;
    assign s_axi_wready  = s.bus.awv && s.bus.wv;
    assign s_axi_bvalid  = s.bus.bvalid;
    assign s_axi_bresp   = s.bus.bresp;
    assign s_axi_arready = !s.bus.rvalid;
    assign s_axi_rvalid  = s.bus.rvalid;
    assign s_axi_rdata   = s.bus.rdata;
    assign s_axi_rresp   = s.bus.rresp;
    assign motor1Drive   = s.out1;
    assign motor2Drive   = s.out2;
    assign motorsOff     = s.estop;

    property p_stop_now;
        @(posedge clk) disable iff (reset) (programButton && setButton) |=> (s.out1 == 8'h0 && s.out2 == 8'h0);
    endproperty
    a_stop_now: assert property (p_stop_now) else $error("Buttons did not cut output");

    property p_stop_held;
        @(posedge clk) disable iff (reset) s.estop |=> s.estop;
    endproperty
    a_stop_held: assert property (p_stop_held) else $error("Emergency stop cleared");

    property p_stop_zero;
        @(posedge clk) disable iff (reset) s.estop |-> (motor1Drive == 8'h0 && motor2Drive == 8'h0);
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("Motor driven while stopped");

    property p_flip_gate;
        @(posedge clk) disable iff (reset) s.flip |-> $past(s.ctrl.mixed && s.ctrl.sw == 2'h2);
    endproperty
    a_flip_gate: assert property (p_flip_gate) else $error("Inversion outside mixed mode");

    property p_sw_stable;
        @(posedge clk) disable iff (reset) $changed(s.swState) |-> $past(s.invCnt) == 27'(INV_CYCLES - 1);
    endproperty
    a_sw_stable: assert property (p_sw_stable) else $error("Switch accepted too soon");

    property p_hot_stop;
        @(posedge clk) disable iff (reset) (s.hs == mcs_pkg::MCS_HS_OK && hot && s.ctrl.hot == 2'h0)
            |=> s.hs == mcs_pkg::MCS_HS_STOP;
    endproperty
    a_hot_stop: assert property (p_hot_stop) else $error("Overheat stop missing");

    property p_cool;
        @(posedge clk) disable iff (reset) (s.hs != mcs_pkg::MCS_HS_OK && !hot) |=> s.hs == mcs_pkg::MCS_HS_OK;
    endproperty
    a_cool: assert property (p_cool) else $error("No recovery after cooling");

    property p_lin;
        @(posedge clk) disable iff (reset) (!next_s.estop && s.hs == mcs_pkg::MCS_HS_OK && s.ctrl.curve1 == 3'h0
            && s.ctrl.tune == 4'h7 && !s.flip) |=> s.out1 == $past(s.cmd1[6:0] == 7'h0 ? 8'h0 : s.cmd1);
    endproperty
    a_lin: assert property (p_lin) else $error("Linear curve altered command");
endmodule : mcs_motor_shaping

// [mcs_defs.svh]
// Register offsets, reset values and timing counts
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
`define MCS_OFF_CTRL      12'h000
`define MCS_OFF_CMD       12'h004
`define MCS_OFF_TEMP      12'h008
`define MCS_OFF_STATUS    12'h00c
`define MCS_OFF_OUT       12'h010
`define MCS_CTRL_RESET    25'h00011c0
`define MCS_THR_RESET     8'h00
`define MCS_TUNE_NEUTRAL  4'h7
`define MCS_CLK_MHZ       200
`define MCS_INV_MS        500
`define MCS_INV_CYCLES    (`MCS_INV_MS * `MCS_CLK_MHZ * 1000)
`define MCS_DER1_S        30
`define MCS_DER1_CYCLES   (`MCS_DER1_S * `MCS_CLK_MHZ * 64'h0000_0000_000f_4240)
`define MCS_DER2_S        120
`define MCS_DER2_CYCLES   (`MCS_DER2_S * `MCS_CLK_MHZ * 64'h0000_0000_000f_4240)
`define MCS_THR_MIN       8'h3c
`define MCS_THR_MAX       8'h78
`endif

// [mcs_pkg.sv]
// Types of the motor command shaping block
package mcs_pkg;
    typedef enum logic [2:0] {MCS_HOT_STOP = 3'h0, MCS_HOT_D50 = 3'h1, MCS_HOT_D25 = 3'h2, MCS_HOT_NONE = 3'h3}
        mcs_hot_e;
    typedef enum logic [1:0] {MCS_SW_NONE = 2'h0, MCS_SW_STOP = 2'h1, MCS_SW_FLIP = 2'h2} mcs_sw_e;
    typedef enum logic [2:0] {MCS_HS_OK = 3'b001, MCS_HS_DERATE = 3'b010, MCS_HS_STOP = 3'b100} mcs_hs_e;
    typedef struct packed {
        logic [7:0] thr;
        logic       mixed;
        logic       cl2;
        logic       cl1;
        logic [1:0] hot;
        logic [1:0] sw;
        logic [3:0] tune;
        logic [2:0] curve2;
        logic [2:0] curve1;
    } mcs_ctrl_s;
    typedef struct packed {
        logic        awv;
        logic        wv;
        logic [11:0] awa;
        logic [31:0] wd;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
    } mcs_bus_s;
    typedef struct packed {
        mcs_bus_s         bus;
        mcs_ctrl_s        ctrl;
        logic [7:0]       cmd1;
        logic [7:0]       cmd2;
        logic [7:0]       temp1;
        logic [7:0]       temp2;
        logic [2:0]       pin;
        logic             swState;
        logic [26:0]      invCnt;
        logic             flip;
        logic             estop;
        mcs_hs_e          hs;
        logic [34:0]      hotCnt;
        logic [7:0]       out1;
        logic [7:0]       out2;
    } mcs_state_s;
endpackage : mcs_pkg

// [mcs_cmd_source.sv]
// Command source model: operator buttons and external switch
`timescale 1ns/10ps
module mcs_cmd_source
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Requests from the bench
    input  wire logic [1:0] pressReq,
    input  wire logic       closeReq,
    // Pins toward the controller
    output logic            programButton,
    output logic            setButton,
    output logic            switchClosed
);
    always_ff @(posedge clk)
    begin
        programButton <= pressReq[0] & !reset;
        setButton     <= pressReq[1] & !reset;
        switchClosed  <= closeReq & !reset;
    end
endmodule : mcs_cmd_source

// [mcs_motor_shaping_tb_top.sv]
// Testbench for the motor command shaping block
`timescale 1ns/10ps
`include "mcs_defs.svh"
module mcs_motor_shaping_tb_top;
    logic               clk = 0, reset = 1;
    logic [11:0]        awAddr = '0, arAddr = '0;
    logic [31:0]        wData = '0, rData;
    logic               awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic               awReady, wReady, bValid, arReady, rValid;
    logic [1:0]         bResp, rResp, pressReq = '0;
    logic               closeReq = 0, pgm, setB, swC, motorsOff;
    logic [7:0]         m1, m2;
    logic [7:0]         mid [1:4];
    mcs_pkg::mcs_ctrl_s cfg;
    int                 miscompares = 0, n_tests = 0, cyc = 0;

    mcs_motor_shaping #(.INV_CYCLES(20), .DER1_CYCLES(50), .DER2_CYCLES(100)) DUT (.clk(clk), .reset(reset),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .programButton(pgm), .setButton(setB), .external_stop_or_flip_input(swC),
        .motor1Drive(m1), .motor2Drive(m2), .motorsOff(motorsOff));
    mcs_cmd_source src (.clk(clk), .reset(reset), .pressReq(pressReq), .closeReq(closeReq),
        .programButton(pgm), .setButton(setB), .switchClosed(swC));

    initial forever #2.5 clk = ~clk;

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            results;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic checkr(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : checkr

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awAddr <= a;
        wData <= d;
        awValid <= 1;
        wValid <= 1;
        bReady <= 1;
        while (!(ad && dd))
        begin
            @(posedge clk);
            ad = ad || awReady === 1'b1;
            dd = dd || wReady === 1'b1;
            awValid <= !ad;
            wValid <= !dd;
        end
        while (bValid !== 1'b1) @(posedge clk);
        bReady <= 0;
        check(32'(bResp), 32'(er));
        @(posedge clk);
    endtask : axw

    task automatic axr(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1;
        rReady <= 1;
        do @(posedge clk); while (arReady !== 1'b1);
        arValid <= 0;
        while (rValid !== 1'b1) @(posedge clk);
        rReady <= 0;
        check(rData & mask, exp);
        check(32'(rResp), 32'(er));
        @(posedge clk);
    endtask : axr

    task automatic defc;
        cfg = '0;
        cfg.tune = `MCS_TUNE_NEUTRAL;
        cfg.hot = 2'h1;
    endtask : defc

    task automatic setc;
        axw(`MCS_OFF_CTRL, 32'(cfg), 2'h0);
    endtask : setc

    task automatic cmd(input logic [7:0] c1, input logic [7:0] c2);
        axw(`MCS_OFF_CMD, {16'h0, c2, c1}, 2'h0);
        idle(3);
    endtask : cmd

    task automatic temp(input logic [7:0] t1, input logic [7:0] t2, input int n);
        axw(`MCS_OFF_TEMP, {16'h0, t2, t1}, 2'h0);
        idle(n);
    endtask : temp

    task automatic outs(input logic off, input logic [7:0] e1, input logic [7:0] e2);
        check(32'({motorsOff, m2, m1}), 32'({off, e2, e1}));
    endtask : outs

    task automatic tcase(input logic [3:0] tn, input logic [2:0] cv, input logic cl, input logic [7:0] c1,
                         input logic [7:0] lo, input logic [7:0] hi);
        cfg.tune = tn;
        cfg.curve1 = cv;
        cfg.cl1 = cl;
        setc;
        cmd(c1, 8'h7f);
        checkr(m1, lo, hi);
    endtask : tcase

    task automatic restart;
        reset <= 1;
        idle(2);
        reset <= 0;
        @(posedge clk);
        defc;
    endtask : restart

    task automatic done(input string s);
        $display("Test %s finished, mismatches so far %0d", s, miscompares);
    endtask : done

    initial
    begin
        defc;
        idle(12);
        reset <= 0;
        @(posedge clk);
        axr(`MCS_OFF_CTRL, '1, 32'(cfg), 2'h0);
        axw(`MCS_OFF_STATUS, 32'h0, 2'h2);
        axw(12'h020, 32'h0, 2'h2);
        axr(12'h014, '1, 32'h0, 2'h2);
        done("registers");
        cmd(8'h40, 8'hc0);
        outs(0, 8'h40, 8'hc0);
        for (int k = 1; k <= 4; k++)
        begin
            cfg.curve1 = 3'(k);
            setc;
            cmd(8'h7f, 8'h40);
            if (k < 3) checkr(m1, 8'h7f, 8'h7f);
            cmd(8'h40, 8'h40);
            mid[k] = m1;
            checkr(m2, 8'h40, 8'h40);
            if (k < 3) checkr(m1, 8'h01, 8'h3f);
            else checkr(m1, 8'h41, 8'h7f);
        end
        check(32'(mid[1] < mid[2]), 32'h1);
        check(32'(mid[4] > mid[3]), 32'h1);
        done("curves");
        tcase(4'he, 3'h0, 1'b0, 8'hff, 8'hf0, 8'hf2);
        checkr(m2, 8'h7f, 8'h7f);
        tcase(4'he, 3'h0, 1'b0, 8'h8a, 8'h88, 8'h89);
        tcase(4'hd, 3'h0, 1'b0, 8'hff, 8'hf2, 8'hf4);
        tcase(4'h0, 3'h0, 1'b0, 8'h7f, 8'h70, 8'h72);
        tcase(4'he, 3'h1, 1'b0, 8'hff, 8'hf0, 8'hf2);
        tcase(4'he, 3'h0, 1'b1, 8'hff, 8'hff, 8'hff);
        done("tuning");
        defc;
        setc;
        cmd(8'h40, 8'h40);
        pressReq <= 2'b01;
        idle(6);
        outs(0, 8'h40, 8'h40);
        pressReq <= 2'b11;
        idle(3);
        outs(1, 8'h00, 8'h00);
        pressReq <= 2'b00;
        cmd(8'h30, 8'h30);
        outs(1, 8'h00, 8'h00);
        restart;
        cmd(8'h40, 8'h40);
        outs(0, 8'h40, 8'h40);
        closeReq <= 1;
        idle(10);
        outs(0, 8'h40, 8'h40);
        closeReq <= 0;
        cfg.sw = 2'h1;
        setc;
        idle(4);
        closeReq <= 1;
        idle(30);
        outs(1, 8'h00, 8'h00);
        closeReq <= 0;
        idle(8);
        outs(1, 8'h00, 8'h00);
        restart;
        done("stops");
        cfg.sw = 2'h2;
        setc;
        cmd(8'h40, 8'h00);
        closeReq <= 1;
        idle(40);
        outs(0, 8'h40, 8'h00);
        closeReq <= 0;
        idle(40);
        cfg.mixed = 1;
        setc;
        closeReq <= 1;
        idle(10);
        axr(`MCS_OFF_STATUS, 32'h8, 32'h0, 2'h0);
        closeReq <= 0;
        idle(40);
        axr(`MCS_OFF_STATUS, 32'h8, 32'h0, 2'h0);
        closeReq <= 1;
        idle(40);
        axr(`MCS_OFF_STATUS, 32'h8, 32'h8, 2'h0);
        check(32'(m1[7]), 32'h1);
        closeReq <= 0;
        restart;
        done("inversion");
        cfg.thr = 8'h3c;
        cfg.hot = 2'h0;
        setc;
        cmd(8'h7f, 8'h7f);
        temp(8'h3c, 8'h00, 4);
        outs(0, 8'h00, 8'h00);
        temp(8'h3b, 8'h00, 4);
        outs(0, 8'h7f, 8'h7f);
        cfg.hot = 2'h1;
        setc;
        temp(8'h00, 8'h50, 6);
        checkr(m1, 8'h3f, 8'h40);
        idle(60);
        outs(0, 8'h00, 8'h00);
        temp(8'h00, 8'h00, 4);
        outs(0, 8'h7f, 8'h7f);
        temp(8'h50, 8'h00, 20);
        temp(8'h00, 8'h00, 60);
        outs(0, 8'h7f, 8'h7f);
        cfg.hot = 2'h2;
        setc;
        temp(8'h50, 8'h00, 6);
        checkr(m2, 8'h1f, 8'h20);
        idle(60);
        checkr(m2, 8'h1f, 8'h20);
        idle(50);
        outs(0, 8'h00, 8'h00);
        temp(8'h00, 8'h00, 4);
        cfg.hot = 2'h3;
        setc;
        temp(8'hff, 8'hff, 10);
        outs(0, 8'h7f, 8'h7f);
        cfg.hot = 2'h0;
        cfg.thr = 8'h78;
        setc;
        temp(8'h77, 8'h77, 4);
        outs(0, 8'h7f, 8'h7f);
        temp(8'h00, 8'h78, 4);
        outs(0, 8'h00, 8'h00);
        cfg.thr = 8'h00;
        setc;
        temp(8'hff, 8'hff, 4);
        outs(0, 8'h7f, 8'h7f);
        done("overheat");
        results;
    end
endmodule : mcs_motor_shaping_tb_top
